// >>> rtl/rchc_pkg.sv
// shared constants and types for the reset, clock and halt controller
package rchc_pkg;
    localparam int unsigned SYS_CLK_HZ     = 25_000_000;
    localparam int unsigned HZ_PER_MHZ     = 1_000_000;
    // oscillator settling after a wake from halt, in microseconds
    localparam int unsigned OSC_SETTLE_US  = 1000;
    localparam int unsigned OSC_SETTLE_CYC = OSC_SETTLE_US * (SYS_CLK_HZ / HZ_PER_MHZ);
    // clock start-up delay after a reset, in microseconds
    localparam int unsigned RST_START_US   = 1000;
    localparam int unsigned RST_START_CYC  = RST_START_US * (SYS_CLK_HZ / HZ_PER_MHZ);

    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] ADDR_INIT   = 8'h00;
    localparam logic [7:0] ADDR_PMODE  = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    localparam int unsigned CSEL_LSB = 0;
    localparam int unsigned CSEL_W   = 2;
    localparam logic [1:0] CSEL_INT  = 2'h0;
    localparam logic [1:0] CSEL_SQR  = 2'h1;
    localparam logic [1:0] CSEL_XTAL = 2'h2;
    localparam logic [1:0] CSEL_RSVD = 2'h3;
    localparam logic [1:0] CSEL_RST  = 2'h0;

    localparam int unsigned HALT_BIT = 0;
    localparam int unsigned IDLE_BIT = 1;

    localparam int unsigned ST_CAUSE_LSB = 0;
    localparam int unsigned ST_CLKRUN    = 4;
    localparam int unsigned ST_HALTED    = 5;
    localparam int unsigned ST_OSCEN     = 6;

    typedef struct packed {
        logic por;
        logic bor;
        logic wdt;
        logic ext;
    } rchc_rst_src_t;

    typedef struct packed {
        logic oscEn;
        logic borEn;
        logic lbdEn;
    } rchc_pwr_t;

    localparam rchc_pwr_t PWR_RST = 3'h7;

    typedef enum logic [2:0] {
        ST_RST_HOLD,
        ST_RST_WAIT,
        ST_RUN,
        ST_HALT,
        ST_WAKE_WAIT
    } rchc_state_t;
endpackage

// >>> rtl/rchc_delay_timer.sv
// down counter that times the clock start-up and oscillator settling delays
module rchc_delay_timer #(
    parameter int unsigned MAX_CYC = rchc_pkg::OSC_SETTLE_CYC,
    parameter int unsigned W       = $clog2(MAX_CYC + 1)
) (
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    input  wire logic         start,
    input  wire logic [W-1:0] loadVal,
    output logic              done
);
    logic [W-1:0] count_r;

    // a start restarts the count even mid-run
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_r <= '0;
        end else if (start) begin
            count_r <= loadVal;
        end else if (count_r != '0) begin
            count_r <= count_r - W'(1);
        end
    end

    // done in the last counted cycle, so the wait lasts exactly loadVal cycles
    assign done = (count_r == W'(1)) && !start;
endmodule

// >>> rtl/rchc_clk_gen.sv
// system clock tick generation from the selected clock source
module rchc_clk_gen (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic [1:0] clkSel,
    input  wire logic       run,
    input  wire logic       oscTick,
    input  wire logic       extClkIn,
    output logic            sysClkTick,
    output logic            ckoOut
);
    logic divPh_r;
    logic extPrev_r;
    logic sysClkTick_r;
    logic ckoOut_r;
    logic extRise;

    assign extRise = extClkIn && !extPrev_r;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            divPh_r   <= 1'b0;
            extPrev_r <= 1'b0;
        end else begin
            extPrev_r <= extClkIn;
            if (oscTick) begin
                divPh_r <= !divPh_r;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sysClkTick_r <= 1'b0;
        end else begin
            case (clkSel)
                rchc_pkg::CSEL_INT:  sysClkTick_r <= run && oscTick && divPh_r; // see R4
                rchc_pkg::CSEL_SQR:  sysClkTick_r <= run && extRise; // see R8
                rchc_pkg::CSEL_XTAL: sysClkTick_r <= run && extRise;
                default:             sysClkTick_r <= 1'b0; // see R16
            endcase
        end
    end

    // inverting amplifier stage for the crystal, only meaningful in crystal mode
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ckoOut_r <= 1'b0;
        end else begin
            ckoOut_r <= (clkSel == rchc_pkg::CSEL_XTAL) && !extClkIn; // see R7
        end
    end

    assign sysClkTick = sysClkTick_r;
    assign ckoOut     = ckoOut_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_int_div;
        (clkSel == rchc_pkg::CSEL_INT) && run && oscTick && divPh_r |=> sysClkTick_r;
    endproperty
    a_int_div: assert property (p_int_div) else $error("internal divide tick missing"); // R4

    property p_int_half;
        (clkSel == rchc_pkg::CSEL_INT) && oscTick && !divPh_r |=> !sysClkTick_r;
    endproperty
    a_int_half: assert property (p_int_half) else $error("tick on odd oscillator edge"); // R4

    property p_sqr_direct;
        (clkSel == rchc_pkg::CSEL_SQR) && run && extClkIn && !extPrev_r |=> sysClkTick_r;
    endproperty
    a_sqr_direct: assert property (p_sqr_direct) else $error("square clock was divided"); // R8
endmodule

// >>> rtl/rchc_top.sv
// reset sequencer, clock source selection and halt control with avalon register access
//
// Overview of operation
// R1 - any reset sequence puts every I/O register back to reset so all pins become hi-Z inputs; here pin zero stays driven in crystal mode.
// R2 - after a reset the system clock stays stopped until the start-up delay has passed.
// R3 - a reset starts on power-on, brown-out, watchdog expiry or the external reset input.
// R4 - in internal mode the 2MHz oscillator is divided by two to give a 1MHz system clock.
// R5 - the oscillator runs at all times except in halt or with an external source selected.
// R6 - the two-bit clock select picks internal, external square or crystal; 11 is reserved.
// R7 - in crystal mode the oscillator output is driven on pin zero with the input on pin one.
// R8 - an external square clock is used directly, with no divide-by-two.
// R9 - software enters halt by setting the halt enable bit in the power-mode register.
// R10 - the halt enable bit is write-only and clears itself when halt is left.
// R11 - entering halt stops the oscillator, the low-battery detector and the brown-out reset.
// R12 - halt is left only on a multi-input wake-up event, which software sets up beforehand; here a reset source also leaves it.
// R13 - after a wake-up the oscillator gets 1ms to settle before execution resumes.
// R14 - power-mode register bit 0 is halt enable, bit 1 idle enable, bits 7 to 2 undefined.
// R15 - the external reset input must be held low at least 2ms by whoever drives it.
// R16 - the reserved clock select code 11 is never taken as a clock source.
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
module rchc_top #(
    parameter int unsigned RST_CYC  = rchc_pkg::RST_START_CYC,
    parameter int unsigned WAKE_CYC = rchc_pkg::OSC_SETTLE_CYC
) (
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    input  wire logic [rchc_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [3:0]                  avs_byteenable,
    input  wire logic [31:0]                 avs_writedata,
    output logic      [31:0]                 avs_readdata,
    output logic                             avs_waitrequest,
    input  wire logic                        porDet,
    input  wire logic                        borDet,
    input  wire logic                        wdtExpire,
    input  wire logic                        extRstN,
    input  wire logic                        miwWake,
    input  wire logic                        oscTick,
    input  wire logic                        gpPinOneIn,
    output logic                             gpPinZeroOut,
    output logic                             gpPinZeroOe,
    output logic                             sysClkTick,
    output logic                             clkRun,
    output logic                             ioReset,
    output rchc_pkg::rchc_pwr_t              pwrEnable
);
    localparam int unsigned TMR_MAX = (RST_CYC > WAKE_CYC) ? RST_CYC : WAKE_CYC;
    localparam int unsigned TMR_W   = $clog2(TMR_MAX + 1);

    ////////////////////////////////////////////////////////////////////////////////////////
    // reset sources

    rchc_pkg::rchc_rst_src_t rstSrc;
    rchc_pkg::rchc_state_t   state_r;
    rchc_pkg::rchc_state_t   state_nxt;
    rchc_pkg::rchc_pwr_t     pwrEnable_r;
    rchc_pkg::rchc_rst_src_t cause_r;
    logic                    anySrc;
    logic [1:0]              clkSel_r;
    logic                    haltEn_r;
    logic                    clkRun_r;
    logic                    ioReset_r;
    logic                    gpPinZeroOe_r;
    logic                    tmrStart;
    logic [TMR_W-1:0]        tmrLoad;
    logic                    tmrDone;
    logic                    waitreq_r;
    logic [31:0]             rdata_r;
    logic                    req;
    logic                    wrStb;

    // brown-out detector is powered down in halt, so its output is ignored then
    always_comb begin
        rstSrc.por = porDet;
        rstSrc.bor = borDet && pwrEnable_r.borEn; // see R11
        rstSrc.wdt = wdtExpire;
        rstSrc.ext = !extRstN; // see R3
    end

    assign anySrc = |rstSrc; // see R3

    ////////////////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb begin
        state_nxt = state_r;
        tmrStart  = 1'b0;
        tmrLoad   = TMR_W'(RST_CYC);
        if (anySrc) begin
            state_nxt = rchc_pkg::ST_RST_HOLD; // see R3
        end else begin
            case (state_r)
                rchc_pkg::ST_RST_HOLD: begin
                    state_nxt = rchc_pkg::ST_RST_WAIT;
                    tmrStart  = 1'b1;
                end
                rchc_pkg::ST_RST_WAIT: begin
                    if (tmrDone) begin
                        state_nxt = rchc_pkg::ST_RUN; // see R2
                    end
                end
                rchc_pkg::ST_RUN: begin
                    if (haltEn_r) begin
                        state_nxt = rchc_pkg::ST_HALT; // see R9
                    end
                end
                rchc_pkg::ST_HALT: begin
                    if (miwWake) begin
                        state_nxt = rchc_pkg::ST_WAKE_WAIT; // see R12
                        tmrStart  = 1'b1;
                        tmrLoad   = TMR_W'(WAKE_CYC); // see R13
                    end
                end
                rchc_pkg::ST_WAKE_WAIT: begin
                    if (tmrDone) begin
                        state_nxt = rchc_pkg::ST_RUN; // see R13
                    end
                end
                default: state_nxt = rchc_pkg::ST_RST_HOLD;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= rchc_pkg::ST_RST_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    rchc_delay_timer #(
        .MAX_CYC (TMR_MAX),
        .W       (TMR_W)
    ) u_timer (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .start   (tmrStart),
        .loadVal (tmrLoad),
        .done    (tmrDone)
    );

    // cause bits gather every source seen while the reset is held
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cause_r <= '0;
        end else if (anySrc) begin
            cause_r <= (state_r == rchc_pkg::ST_RST_HOLD) ? (cause_r | rstSrc) : rstSrc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // clock, i/o and power outputs

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clkRun_r  <= 1'b0;
            ioReset_r <= 1'b1;
        end else begin
            clkRun_r  <= (state_nxt == rchc_pkg::ST_RUN); // see R2
            ioReset_r <= (state_nxt == rchc_pkg::ST_RST_HOLD) ||
                         (state_nxt == rchc_pkg::ST_RST_WAIT); // see R1
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwrEnable_r <= rchc_pkg::PWR_RST;
        end else begin
            pwrEnable_r.oscEn <= (state_r != rchc_pkg::ST_HALT) &&
                                 (clkSel_r == rchc_pkg::CSEL_INT); // see R5
            pwrEnable_r.borEn <= (state_r != rchc_pkg::ST_HALT); // see R11
            pwrEnable_r.lbdEn <= (state_r != rchc_pkg::ST_HALT); // see R11
        end
    end

    // crystal pin stays driven through reset: the oscillator must keep swinging
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gpPinZeroOe_r <= 1'b0;
        end else begin
            gpPinZeroOe_r <= (clkSel_r == rchc_pkg::CSEL_XTAL); // see R7
        end
    end

    rchc_clk_gen u_clkgen (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .clkSel     (clkSel_r),
        .run        (clkRun_r),
        .oscTick    (oscTick),
        .extClkIn   (gpPinOneIn),
        .sysClkTick (sysClkTick),
        .ckoOut     (gpPinZeroOut)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle on every access

    assign req   = avs_read || avs_write;
    assign wrStb = avs_write && !waitreq_r && avs_byteenable[0];

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            waitreq_r <= 1'b1;
        end else begin
            waitreq_r <= !(req && waitreq_r);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clkSel_r <= rchc_pkg::CSEL_RST;
        end else if (wrStb && (avs_address == rchc_pkg::ADDR_INIT) &&
                     (avs_writedata[rchc_pkg::CSEL_LSB +: rchc_pkg::CSEL_W] !=
                      rchc_pkg::CSEL_RSVD)) begin
            clkSel_r <= avs_writedata[rchc_pkg::CSEL_LSB +: rchc_pkg::CSEL_W]; // see R6 and R16
        end
    end

    // idle enable is accepted but idle mode itself lives elsewhere
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            haltEn_r <= 1'b0;
        end else if (anySrc || (state_r == rchc_pkg::ST_HALT && state_nxt != rchc_pkg::ST_HALT)) begin
            haltEn_r <= 1'b0; // see R10
        end else if (wrStb && (avs_address == rchc_pkg::ADDR_PMODE) &&
                     (state_r == rchc_pkg::ST_RUN)) begin
            haltEn_r <= avs_writedata[rchc_pkg::HALT_BIT]; // see R9 and R14
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= 32'h00000000;
        end else if (avs_read && waitreq_r) begin
            case (avs_address)
                rchc_pkg::ADDR_INIT:   rdata_r <= 32'(clkSel_r);
                rchc_pkg::ADDR_PMODE:  rdata_r <= 32'h00000000; // see R10
                rchc_pkg::ADDR_STATUS: begin
                    rdata_r <= 32'h00000000;
                    rdata_r[rchc_pkg::ST_CAUSE_LSB +: 4] <= cause_r;
                    rdata_r[rchc_pkg::ST_CLKRUN]         <= clkRun_r;
                    rdata_r[rchc_pkg::ST_HALTED]         <= (state_r == rchc_pkg::ST_HALT);
                    rdata_r[rchc_pkg::ST_OSCEN]          <= pwrEnable_r.oscEn;
                end
                default: rdata_r <= 32'h00000000;
            endcase
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = waitreq_r;
    assign clkRun          = clkRun_r;
    assign ioReset         = ioReset_r;
    assign pwrEnable       = pwrEnable_r;
    assign gpPinZeroOe     = gpPinZeroOe_r;

    ////////////////////////////////////////////////////////////////////////////////////////
    // checks

    logic [31:0] waitCnt_r;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            waitCnt_r <= 32'h00000000;
        end else begin
            waitCnt_r <= (state_r == rchc_pkg::ST_WAKE_WAIT) ? waitCnt_r + 32'h00000001
                                                             : 32'h00000000;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_io_reset;
        anySrc |=> ioReset_r && !clkRun_r;
    endproperty
    a_io_reset: assert property (p_io_reset) else $error("io not reset on reset source"); // R1

    property p_clk_restart;
        (state_r == rchc_pkg::ST_RST_WAIT) && tmrDone && !anySrc |=> clkRun_r && !ioReset_r;
    endproperty
    a_clk_restart: assert property (p_clk_restart) else $error("clock not restarted"); // R2

    property p_clk_held;
        $rose(clkRun_r) |-> $past(tmrDone);
    endproperty
    a_clk_held: assert property (p_clk_held) else $error("clock restarted before delay"); // R2

    property p_src;
        !extRstN || wdtExpire || porDet |=> state_r == rchc_pkg::ST_RST_HOLD;
    endproperty
    a_src: assert property (p_src) else $error("reset source ignored"); // R3

    property p_osc_on;
        (state_r == rchc_pkg::ST_RUN) && (clkSel_r == rchc_pkg::CSEL_INT) |=> pwrEnable_r.oscEn;
    endproperty
    a_osc_on: assert property (p_osc_on) else $error("oscillator stopped while running"); // R5

    property p_no_rsvd;
        clkSel_r != rchc_pkg::CSEL_RSVD;
    endproperty
    a_no_rsvd: assert property (p_no_rsvd) else $error("reserved clock select taken"); // R16

    property p_xtal_pin;
        clkSel_r == rchc_pkg::CSEL_XTAL |=> gpPinZeroOe_r;
    endproperty
    a_xtal_pin: assert property (p_xtal_pin) else $error("crystal output not driven"); // R7

    property p_halt_enter;
        (state_r == rchc_pkg::ST_RUN) && haltEn_r && !anySrc |=> state_r == rchc_pkg::ST_HALT;
    endproperty
    a_halt_enter: assert property (p_halt_enter) else $error("halt not entered"); // R9

    property p_halt_clear;
        (state_r == rchc_pkg::ST_HALT) ##1 (state_r != rchc_pkg::ST_HALT) |-> !haltEn_r;
    endproperty
    a_halt_clear: assert property (p_halt_clear) else $error("halt enable not cleared"); // R10

    property p_halt_power;
        (state_r == rchc_pkg::ST_RUN) && haltEn_r && !anySrc |=>
            ##1 !pwrEnable_r.oscEn && !pwrEnable_r.borEn && !pwrEnable_r.lbdEn;
    endproperty
    a_halt_power: assert property (p_halt_power) else $error("halt left systems on"); // R11

    property p_halt_stay;
        (state_r == rchc_pkg::ST_HALT) && !miwWake && !anySrc |=> state_r == rchc_pkg::ST_HALT;
    endproperty
    a_halt_stay: assert property (p_halt_stay) else $error("halt left without wake"); // R12

    property p_wake_len;
        (state_r == rchc_pkg::ST_WAKE_WAIT) && (state_nxt == rchc_pkg::ST_RUN) |->
            waitCnt_r == (WAKE_CYC - 1);
    endproperty
    a_wake_len: assert property (p_wake_len) else $error("wake settle time wrong"); // R13

    property p_pmode_read;
        avs_read && waitreq_r && (avs_address == rchc_pkg::ADDR_PMODE) |=> avs_readdata == 0;
    endproperty
    a_pmode_read: assert property (p_pmode_read) else $error("write-only bits read back"); // R10

    c_run:   cover property ($rose(clkRun_r));
    c_halt:  cover property (state_r == rchc_pkg::ST_HALT);
    c_wake:  cover property ((state_r == rchc_pkg::ST_WAKE_WAIT) ##1 (state_r == rchc_pkg::ST_RUN));
    c_xtal:  cover property (gpPinZeroOe_r && clkRun_r);
endmodule

// >>> tb/test_reset_clock_halt_control.sv
// self-checking bench for the reset, clock source and halt controller
module test_reset_clock_halt_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RST_N = 8;
    localparam int WAKE_N = 10;
    logic                sys_clk = 1'b0;
    logic                sys_rst = 1'b1;
    logic [7:0]          avs_address = 8'h00;
    logic                avs_read = 1'b0;
    logic                avs_write = 1'b0;
    logic [3:0]          avs_byteenable = 4'hF;
    logic [31:0]         avs_writedata = 32'h0;
    logic [31:0]         avs_readdata;
    logic                avs_waitrequest;
    logic                porDet = 1'b0;
    logic                borDet = 1'b0;
    logic                wdtExpire = 1'b0;
    logic                extRstN = 1'b1;
    logic                miwWake = 1'b0;
    logic                oscTick = 1'b0;
    logic                gpPinOneIn = 1'b0;
    logic                gpPinZeroOut, gpPinZeroOe, sysClkTick, clkRun, ioReset;
    rchc_pkg::rchc_pwr_t pwrEnable;
    logic [7:0]          cyc = 8'h00;
    int                  cycles = 0;
    int                  failures = 0;
    int                  comparisons = 0;
    logic [1:0]          rowSel [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    logic [1:0]          rowGot [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
    int                  rowTicks [4] = '{10, 5, 5, 5};
    logic                rowOe [4] = '{1'b0, 1'b0, 1'b1, 1'b1};

    rchc_top #(.RST_CYC(RST_N), .WAKE_CYC(WAKE_N)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .porDet(porDet),
        .borDet(borDet), .wdtExpire(wdtExpire), .extRstN(extRstN), .miwWake(miwWake),
        .oscTick(oscTick), .gpPinOneIn(gpPinOneIn), .gpPinZeroOut(gpPinZeroOut),
        .gpPinZeroOe(gpPinZeroOe), .sysClkTick(sysClkTick), .clkRun(clkRun),
        .ioReset(ioReset), .pwrEnable(pwrEnable));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // oscillator pulses every 2 cycles, pin-one clock period 8 cycles; both divide 40
    always @(posedge sys_clk) begin
        cyc <= cyc + 8'h01;
        oscTick <= cyc[0];
        gpPinOneIn <= cyc[2];
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("Comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // holds the request until waitrequest is sampled low, then releases it
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        // no limit of its own: only the bench timeout ends a hung access
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic waitRun(output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (clkRun !== 1'b1 && n < 300);
    endtask

    task automatic setSrc(input int k, input logic on);
        case (k)
            0: porDet <= on;
            1: borDet <= on;
            2: wdtExpire <= on;
            default: extRstN <= !on;
        endcase
    endtask

    task automatic pulseWake();
        @(posedge sys_clk);
        miwWake <= 1'b1;
        @(posedge sys_clk);
        miwWake <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int          n;
        logic [31:0] rd;
        @(posedge sys_clk);
        #1;
        chk("io reset", ioReset, 1'b1);
        chk("clock run", clkRun, 1'b0);
        chk("power enables", pwrEnable, 3'h7);
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        waitRun(n);
        chk("start-up wait", (n >= RST_N && n <= RST_N + 3), 1'b1);
        // clock source rows, the reserved code must leave crystal in place
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, rchc_pkg::ADDR_INIT, {30'h0, rowSel[i]}, rd);
            bus(1'b0, rchc_pkg::ADDR_INIT, 32'h0, rd);
            chk("clock select", rd, {30'h0, rowGot[i]});
            repeat (8) @(posedge sys_clk);
            n = 0;
            repeat (40) begin
                @(posedge sys_clk);
                #1;
                if (sysClkTick === 1'b1) n++;
            end
            chk("system ticks", n, rowTicks[i]);
            chk("pin zero enable", gpPinZeroOe, rowOe[i]);
            chk("osc enable", pwrEnable.oscEn, rowGot[i] == 2'h0);
            do begin
                @(posedge sys_clk);
                #1;
            end while (cyc[1:0] != 2'h3);
            chk("pin zero out", gpPinZeroOut, rowOe[i] && !gpPinOneIn);
        end
        // each reset source alone, with its cause bit afterwards
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            setSrc(k, 1'b1);
            // source held longer than the start-up wait, as the external reset needs
            repeat (RST_N) @(posedge sys_clk);
            #1;
            chk("io reset", ioReset, 1'b1);
            chk("clock run", clkRun, 1'b0);
            @(posedge sys_clk);
            setSrc(k, 1'b0);
            waitRun(n);
            chk("restart wait", (n >= RST_N && n <= RST_N + 3), 1'b1);
            bus(1'b0, rchc_pkg::ADDR_STATUS, 32'h0, rd);
            chk("reset cause", rd[4:0], {1'b1, 4'h8 >> k});
        end
        // halt entry, refused wake-ups, wake and settling; internal clock so the osc stops
        bus(1'b1, rchc_pkg::ADDR_INIT, 32'h0, rd);
        pulseWake();
        repeat (3) @(posedge sys_clk);
        #1;
        chk("run after stray wake", clkRun, 1'b1);
        bus(1'b1, rchc_pkg::ADDR_PMODE, 32'h2, rd);
        repeat (3) @(posedge sys_clk);
        #1;
        chk("run after idle bit", clkRun, 1'b1);
        bus(1'b1, rchc_pkg::ADDR_PMODE, 32'h1, rd);
        repeat (3) @(posedge sys_clk);
        #1;
        chk("halted clock", clkRun, 1'b0);
        chk("halt power", pwrEnable, 3'h0);
        bus(1'b0, rchc_pkg::ADDR_PMODE, 32'h0, rd);
        chk("power mode read", rd, 32'h0);
        @(posedge sys_clk);
        borDet <= 1'b1;
        repeat (3) @(posedge sys_clk);
        borDet <= 1'b0;
        repeat (20) @(posedge sys_clk);
        #1;
        chk("no brown-out in halt", ioReset, 1'b0);
        chk("still halted", clkRun, 1'b0);
        pulseWake();
        waitRun(n);
        chk("wake settle", (n >= WAKE_N && n <= WAKE_N + 3), 1'b1);
        chk("power back", pwrEnable, 3'h7);
        bus(1'b0, rchc_pkg::ADDR_STATUS, 32'h0, rd);
        chk("halted flag", rd[5], 1'b0);
        bus(1'b0, 8'h0C, 32'h0, rd);
        chk("unmapped read", rd, 32'h0);
        report_and_stop();
    end
endmodule
